// ---- verilog/ast_device.sv ----
/*
 Device end: serial slave, self-test control, parity monitor, readout.
 Assumes core_clk is much faster than the link clock; link inputs asynchronous.
*/
`timescale 1ns/10ps
module ast_device (
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    ast_link_if.dev                         link,
    input  wire logic [ast_pkg::ACC_W-1:0]  ch1_adc,
    input  wire logic [ast_pkg::ACC_W-1:0]  ch2_adc,
    input  wire logic [ast_pkg::TEMP_W-1:0] temp_adc,
    input  wire logic [ast_pkg::CAL_W-1:0]  cal_word,
    input  wire logic                       cal_parity,
    input  wire logic [ast_pkg::CAL_W-1:0]  nvm_word,
    input  wire logic                       nvm_parity,
    output logic                            ch1_selftest,
    output logic                            ch2_selftest,
    output logic                            cal_reload,
    output logic                            fail_forced
);
    import ast_pkg::*;

    logic [2:0]            sck_s;
    logic [2:0]            cs_s;
    logic [2:0]            mosi_s;
    logic [2:0]            p1_s;
    logic [2:0]            p2_s;
    logic                  sck_q;
    logic                  cs_q;
    logic                  p1_q;
    logic                  p2_q;
    logic                  sck_rise;
    logic                  sck_fall;
    logic [BIT_CNT_W-1:0]  bit_cnt;
    logic [CMD_W-1:0]      cmd_sh;
    logic [ACC_W-1:0]      out_sh;
    logic                  out_en;
    logic                  st1_cmd;
    logic                  st2_cmd;
    logic                  reloaded;
    logic                  fail_latch;
    logic [CAL_W-1:0]      ctl_word;
    logic                  ctl_par;
    logic [ACC_W-1:0]      res1;
    logic [ACC_W-1:0]      res2;
    logic [TEMP_W-1:0]     temp_hold;
    logic [CMD_W-1:0]      next_cmd;

    // Three-stage synchronisers for all link pins
    // Stages two and three must agree before a clock, select or self-test pin level is believed, so a
    // one-cycle glitch there is dropped; mosi reaches the command decoder from stage three unfiltered
    always_ff @(posedge core_clk) begin
        sck_s  <= {sck_s[1:0], link.sck};
        cs_s   <= {cs_s[1:0], link.cs_n};
        mosi_s <= {mosi_s[1:0], link.mosi};
        p1_s   <= {p1_s[1:0], link.ch1_selftest_pin};
        p2_s   <= {p2_s[1:0], link.ch2_selftest_pin};
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
            p1_q  <= 1'b0;
            p2_q  <= 1'b0;
        end else begin
            if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
            if (cs_s[1] == cs_s[2])   cs_q  <= cs_s[2];
            if (p1_s[1] == p1_s[2])   p1_q  <= p1_s[2];
            if (p2_s[1] == p2_s[2])   p2_q  <= p2_s[2];
        end
    end

    // Link clock edges, seen only while selected
    // The edge is flagged in the cycle the filtered level is about to move
    assign sck_rise = !cs_q && (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;
    assign sck_fall = !cs_q && (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_q;
    assign next_cmd = {cmd_sh[CMD_W-2:0], mosi_s[2]};

    // Command shift and bit count; chip-select release clears both
    always_ff @(posedge core_clk) begin
        if (srst || cs_q) begin
            bit_cnt <= '0;
            cmd_sh  <= '0;
        end else if (sck_rise && bit_cnt < BIT_CNT_W'(CMD_W)) begin
            bit_cnt <= bit_cnt + 1'b1;
            cmd_sh  <= next_cmd;
        end
    end

    // Self-test state held across chip-select, cleared by measure
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st1_cmd <= 1'b0;
            st2_cmd <= 1'b0;
        end else if (sck_rise && bit_cnt == BIT_CNT_W'(CMD_W - 1)) begin
            case (next_cmd)
                MEASURE_CMD: begin
                    st1_cmd <= 1'b0;
                    st2_cmd <= 1'b0;
                end
                SELFTEST_CH1_CMD: st1_cmd <= 1'b1;
                SELFTEST_CH2_CMD: st2_cmd <= 1'b1;
                default: ;
            endcase
        end
    end

    // Command or pin activates a channel; host keeps the pins exclusive, but not the commands
    assign ch1_selftest = st1_cmd || p1_q;
    assign ch2_selftest = st2_cmd || p2_q;

    // Continuous parity check of the live control word
    // After a reload the stored copy stays under check, so a second
    // mismatch latches the failure until reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctl_word   <= nvm_word_reset();
            ctl_par    <= 1'b0;
            reloaded   <= 1'b0;
            fail_latch <= 1'b0;
            cal_reload <= 1'b0;
        end else begin
            cal_reload <= 1'b0;
            if (!reloaded) begin
                ctl_word <= cal_word;
                ctl_par  <= cal_parity;
            end
            if (ast_parity(ctl_word) != ctl_par && !fail_latch) begin
                if (!reloaded) begin
                    ctl_word   <= nvm_word;
                    ctl_par    <= nvm_parity;
                    reloaded   <= 1'b1;
                    cal_reload <= 1'b1;
                end else begin
                    fail_latch <= 1'b1;
                end
            end
        end
    end
    assign fail_forced = fail_latch;

    function automatic logic [CAL_W-1:0] nvm_word_reset();
        return '0;
    endfunction

    // Result registers, frozen while the device is selected
    // Between frames they track the converters, so every frame reads one
    // consistent snapshot; a latched failure overrides both channels
    always_ff @(posedge core_clk) begin
        if (srst) begin
            res1      <= ACC_MIN_NORMAL;
            res2      <= ACC_MIN_NORMAL;
            temp_hold <= '0;
        end else if (cs_q) begin
            temp_hold <= temp_adc;
            if (fail_latch) begin
                res1 <= ACC_FAIL_LOW;
                res2 <= ACC_FAIL_LOW;
            end else begin
                res1 <= ch1_selftest ? ACC_FULL_SCALE : ch1_adc;
                res2 <= ch2_selftest ? ACC_FULL_SCALE : ch2_adc;
            end
        end
    end

    // Output shifter: loaded after command, shifted at falling clock
    // Unknown commands leave the enable low and data out undriven
    always_ff @(posedge core_clk) begin
        if (srst || cs_q) begin
            out_sh <= '0;
            out_en <= 1'b0;
        end else if (sck_rise && bit_cnt == BIT_CNT_W'(CMD_W - 1)) begin
            case (next_cmd)
                READ_CH1_CMD: begin
                    out_sh <= res1;
                    out_en <= 1'b1;
                end
                READ_CH2_CMD: begin
                    out_sh <= res2;
                    out_en <= 1'b1;
                end
                TEMP_READ_CMD: begin
                    out_sh <= {temp_hold, 3'h0};
                    out_en <= 1'b1;
                end
                default: out_en <= 1'b0;
            endcase
        end else if (sck_fall && bit_cnt == BIT_CNT_W'(CMD_W) && out_en) begin
            out_sh <= {out_sh[ACC_W-2:0], 1'b0};
        end
    end

    // Data appears at first falling clock after the command
    // Top bit is copied out in the same cycle that the shifter moves,
    // so each falling clock presents the next bit, MSB first
    logic shown;
    always_ff @(posedge core_clk) begin
        if (srst || cs_q) begin
            shown     <= 1'b0;
            link.miso <= 1'b0;
        end else if (sck_fall && out_en && bit_cnt == BIT_CNT_W'(CMD_W)) begin
            shown     <= 1'b1;
            link.miso <= out_sh[ACC_W-1];
        end
    end
    // Enable trails chip-select release by the synchroniser delay, four
    // core clocks; the testbench, not the host, keeps frames apart by more than that
    assign link.miso_oe = out_en && shown && !cs_q;
endmodule

// ---- verilog/ast_pkg.sv ----
/*
 Constants for the accelerometer self-test and failure monitor link.
 Assumes both ends run from core_clk at 250 MHz and share this package.
*/
// Behaviour
// - Any failure drives outputs outside 102..1945
// - Calibration parity checked continuously
// - Parity error reloads calibration from nonvolatile store
// - Repeat parity error forces results below 102
// - Self-test command enters, measure command leaves
// - Self-test pin high activates channel self-test
// - Never self-test both channels at once; only the host's pins are exclusive, both commands can still be set
// - Self-test drives selected channel to maximum
// - Hold self-test active 20 to 100 ms
// - Wait saturation and recovery before trusting readings
// - Temperature readable as unsigned 8-bit value
// - Host converts temperature: (counts-197)/-1.083
// - Command 00000000 is measure
// - Command 00001110 starts channel one self-test
// - Command 00001111 starts channel two self-test
package ast_pkg;
    localparam int          CMD_W          = 8;
    localparam int          ACC_W          = 11;
    localparam int          TEMP_W         = 8;
    localparam int          CAL_W          = 16;
    localparam int          BIT_CNT_W      = 5;
    localparam logic [7:0]  MEASURE_CMD    = 8'h00;
    localparam logic [7:0]  TEMP_READ_CMD  = 8'h08;
    localparam logic [7:0]  SELFTEST_CH1_CMD = 8'h0e;
    localparam logic [7:0]  SELFTEST_CH2_CMD = 8'h0f;
    localparam logic [7:0]  READ_CH1_CMD   = 8'h10;
    localparam logic [7:0]  READ_CH2_CMD   = 8'h11;
    localparam logic [10:0] ACC_MIN_NORMAL = 11'h066;   // 102
    localparam logic [10:0] ACC_MAX_NORMAL = 11'h799;   // 1945
    localparam logic [10:0] ACC_FAIL_LOW   = 11'h000;
    localparam logic [10:0] ACC_FULL_SCALE = 11'h7ff;
    localparam int          CLK_MHZ        = 250;
    localparam int          SCK_HALF_NS    = 1000;      // 500 kHz link clock
    localparam int          SCK_HALF_CYC   = SCK_HALF_NS * CLK_MHZ / 1000;
    localparam int          SELFTEST_MS    = 20;
    localparam int          SETTLE_MS      = 55;
    localparam int          SELFTEST_CYC   = SELFTEST_MS * CLK_MHZ * 1000;
    localparam int          SETTLE_CYC     = SETTLE_MS * CLK_MHZ * 1000;
    localparam int          DIV_W          = 9;
    localparam int          WAIT_W         = 24;
    typedef enum logic [2:0] {
        AST_OP_NONE, AST_OP_MEASURE, AST_OP_ST1, AST_OP_ST2,
        AST_OP_READ1, AST_OP_READ2, AST_OP_TEMP
    } ast_op_type;
    // Even parity over the calibration word
    function automatic logic ast_parity(input logic [CAL_W-1:0] w);
        return ^w;
    endfunction
endpackage

// ---- verilog/ast_link_if.sv ----
/*
 Serial link between controller and accelerometer monitor.
 Assumes the bench resolves the data-out enable into a wire.
*/
`timescale 1ns/10ps
interface ast_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic ch1_selftest_pin;
    logic ch2_selftest_pin;
    modport dev  (input sck, cs_n, mosi, ch1_selftest_pin, ch2_selftest_pin,
                  output miso, miso_oe);
    modport host (output sck, cs_n, mosi, ch1_selftest_pin, ch2_selftest_pin,
                  input miso, miso_oe);
endinterface

// ---- verilog/ast_host.sv ----
/*
 Host end: serial master that issues one command frame and reads data.
 Assumes the user keeps self-test exclusive and spaced per timing limits.
*/
`timescale 1ns/10ps
module ast_host (
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    ast_link_if.host                        link,
    input  wire logic                       req_valid,
    input  wire logic [ast_pkg::CMD_W-1:0]  req_cmd,
    input  wire logic [4:0]                 req_rd_bits,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [ast_pkg::ACC_W-1:0]       rsp_data,
    input  wire logic                       pin1_req,
    input  wire logic                       pin2_req
);
    import ast_pkg::*;

    typedef enum {H_IDLE, H_LOW, H_HIGH, H_DONE} ast_hstate_type;
    ast_hstate_type       state;
    logic [DIV_W-1:0]     div;
    logic                 tick;
    logic [4:0]           left;
    logic [CMD_W-1:0]     tx;
    logic [ACC_W-1:0]     rx;
    logic [2:0]           miso_s;

    // Half-period enable for the link clock
    assign tick = (div == DIV_W'(SCK_HALF_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (srst || state == H_IDLE) div <= '0;
        else if (tick) div <= '0;
        else div <= div + 1'b1;
    end

    always_ff @(posedge core_clk) miso_s <= {miso_s[1:0], link.miso};

    assign req_ready = (state == H_IDLE);
    // Self-test pins; user must never raise both and holds 20-100 ms
    assign link.ch1_selftest_pin = pin1_req && !pin2_req;
    assign link.ch2_selftest_pin = pin2_req && !pin1_req;

    // Frame sequencer: command bits then read bits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state     <= H_IDLE;
            link.cs_n <= 1'b1;
            link.sck  <= 1'b0;
            link.mosi <= 1'b0;
            left      <= '0;
            tx        <= '0;
            rx        <= '0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                H_IDLE: if (req_valid) begin
                    link.cs_n <= 1'b0;
                    link.mosi <= req_cmd[CMD_W-1];
                    tx        <= {req_cmd[CMD_W-2:0], 1'b0};
                    left      <= 5'(CMD_W) + req_rd_bits;
                    rx        <= '0;
                    state     <= H_LOW;
                end
                H_LOW: if (tick) begin
                    link.sck <= 1'b1;
                    rx       <= {rx[ACC_W-2:0], miso_s[2]};
                    left     <= left - 1'b1;
                    state    <= H_HIGH;
                end
                H_HIGH: if (tick) begin
                    link.sck  <= 1'b0;
                    link.mosi <= tx[CMD_W-1];
                    tx        <= {tx[CMD_W-2:0], 1'b0};
                    state     <= (left == '0) ? H_DONE : H_LOW;
                end
                H_DONE: if (tick) begin
                    link.cs_n <= 1'b1;
                    rsp_valid <= 1'b1;
                    rsp_data  <= rx;
                    state     <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule

// ---- test/ast_link_chk.sv ----
/*
 Checker for the serial link between controller and monitor.
 Assumes both ends are design modules sharing one core_clk domain.
*/
`timescale 1ns/10ps
module ast_link_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic ch1_selftest_pin,
    input wire logic ch2_selftest_pin
);
    logic       sck_q;
    logic       cs_q;
    logic [8:0] hold_cnt;
    logic [4:0] rise_cnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // Previous link levels
    always_ff @(posedge core_clk) begin
        sck_q <= sck;
        cs_q  <= cs_n;
    end

    // Cycles since the last link edge
    always_ff @(posedge core_clk) begin
        if (srst || sck != sck_q || cs_n != cs_q) begin
            hold_cnt <= 9'h000;
        end else if (hold_cnt != 9'h1ff) begin
            hold_cnt <= hold_cnt + 9'h001;
        end
    end

    // Clock rises within the current frame
    always_ff @(posedge core_clk) begin
        if (srst || cs_n) begin
            rise_cnt <= 5'h00;
        end else if (sck && !sck_q) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    pins_exclusive_a: assert property (!(ch1_selftest_pin && ch2_selftest_pin))
        else $error("both self-test pins high");
    idle_clock_a: assert property (cs_n |-> !sck)
        else $error("link clock moves outside a frame");
    // Data out may trail deselect by the four-cycle select synchroniser
    released_miso_a: assert property ((cs_n && $past(cs_n, 4)) |-> !miso_oe)
        else $error("data out driven while deselected");
    half_period_a: assert property ((!cs_n && sck != sck_q) |-> hold_cnt inside {[248:250]})
        else $error("link half period wrong");
    mosi_stable_a: assert property ((!cs_n && sck && sck_q) |-> $stable(mosi))
        else $error("command bit moved while clock high");
    miso_stable_a: assert property ((!cs_n && sck && hold_cnt > 9'd8) |-> $stable(miso))
        else $error("read bit moved while clock high");
    oe_after_cmd_a: assert property ($rose(miso_oe) |-> rise_cnt == 5'd8)
        else $error("data out not started after eight command bits");
    frame_len_a: assert property ($rose(cs_n) |-> rise_cnt inside {5'd8, 5'd16, 5'd19})
        else $error("frame length wrong");
    frame_start_a: assert property ($fell(cs_n) |-> !sck && !miso_oe)
        else $error("frame opened with clock or data out active");
endmodule

// ---- test/accel_selftest_failure_monitor_tb_top.sv ----
/*
 Testbench: host and device joined by the link, driven from the user side.
 Assumes the design's constants in ast_pkg and a 4 ns core_clk.
*/
`timescale 1ns/10ps
module accel_selftest_failure_monitor_tb_top;
    import ast_pkg::*;
    localparam logic [ACC_W-1:0]  CH1_VAL  = 11'h2a5;
    localparam logic [ACC_W-1:0]  CH2_VAL  = 11'h13c;
    localparam logic [TEMP_W-1:0] TEMP_VAL = 8'hc5;
    localparam int                CS_GAP   = 8;
    logic             core_clk    = 1'b0;
    logic             srst        = 1'b1;
    logic             req_valid   = 1'b0;
    logic [CMD_W-1:0] req_cmd     = 8'h00;
    logic [4:0]       req_rd_bits = 5'h00;
    logic             pin1_req    = 1'b0;
    logic             pin2_req    = 1'b0;
    logic             cal_parity  = 1'b1;
    logic             nvm_parity  = 1'b1;
    logic             req_ready;
    logic             rsp_valid;
    logic [ACC_W-1:0] rsp_data;
    logic             ch1_selftest;
    logic             ch2_selftest;
    logic             cal_reload;
    logic             fail_forced;
    logic [ACC_W-1:0] got;
    int               err_total   = 0;
    int               compares    = 0;

    // Core clock
    always #2 core_clk = ~core_clk;

    ast_link_if link ();
    ast_device ast_device_i (.core_clk(core_clk), .srst(srst), .link(link),
        .ch1_adc(CH1_VAL), .ch2_adc(CH2_VAL), .temp_adc(TEMP_VAL),
        .cal_word(16'h1234), .cal_parity(cal_parity), .nvm_word(16'h1234),
        .nvm_parity(nvm_parity), .ch1_selftest(ch1_selftest),
        .ch2_selftest(ch2_selftest), .cal_reload(cal_reload), .fail_forced(fail_forced));
    ast_host ast_host_i (.core_clk(core_clk), .srst(srst), .link(link),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_rd_bits(req_rd_bits),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .pin1_req(pin1_req), .pin2_req(pin2_req));
    ast_link_chk ast_link_chk_i (.core_clk(core_clk), .srst(srst), .sck(link.sck),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
        .ch1_selftest_pin(link.ch1_selftest_pin), .ch2_selftest_pin(link.ch2_selftest_pin));

    // Verdict and end of run
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Word comparison
    task automatic chk_word(input logic [ACC_W-1:0] g, input logic [ACC_W-1:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Flag comparison
    task automatic chk_bit(input logic g, input logic e);
        chk_word({10'h000, g}, {10'h000, e});
    endtask

    // Spent wait bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            err_total++;
            finish_test();
        end
    endtask

    // One frame: command plus read clocks, result into got
    task automatic send(input logic [CMD_W-1:0] cmd, input logic [4:0] bits);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        bound(n, 100);
        // Deselect gap long enough for the device's select synchroniser
        repeat (CS_GAP) @(posedge core_clk);
        req_valid   <= 1'b1;
        req_cmd     <= cmd;
        req_rd_bits <= bits;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 12000) begin
            @(posedge core_clk);
            n++;
        end
        bound(n, 12000);
        got = rsp_data;
    endtask

    // Wait for a device flag to reach a level
    task automatic wait_sel(input int sel, input logic val);
        logic [3:0] v;
        int         n;
        n = 0;
        v = {fail_forced, cal_reload, ch2_selftest, ch1_selftest};
        while (v[sel] !== val && n < 200) begin
            @(posedge core_clk);
            v = {fail_forced, cal_reload, ch2_selftest, ch1_selftest};
            n++;
        end
        bound(n, 200);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        send(READ_CH1_CMD, 5'd11);
        chk_word(got, CH1_VAL);
        $display("Test normal read done");
        for (int c = 0; c < 2; c++) begin
            send(c ? SELFTEST_CH2_CMD : SELFTEST_CH1_CMD, 5'd0);
            chk_bit(ch1_selftest, c == 0);
            chk_bit(ch2_selftest, c == 1);
            send(c ? READ_CH2_CMD : READ_CH1_CMD, 5'd11);
            chk_word(got, ACC_FULL_SCALE);
            chk_bit(c ? ch2_selftest : ch1_selftest, 1'b1);
            send(MEASURE_CMD, 5'd0);
            repeat (20) @(posedge core_clk);
            chk_bit(ch1_selftest | ch2_selftest, 1'b0);
        end
        $display("Test self-test commands done");
        send(TEMP_READ_CMD, 5'd8);
        chk_word({3'h0, got[7:0]}, {3'h0, TEMP_VAL});
        // A reading of 197 counts is zero degrees after host conversion
        chk_word(11'(got[7:0]) - 11'h0c5, 11'h000);
        $display("Test temperature read done");
        pin1_req <= 1'b1;
        wait_sel(0, 1'b1);
        pin1_req <= 1'b0;
        wait_sel(0, 1'b0);
        pin2_req <= 1'b1;
        wait_sel(1, 1'b1);
        pin1_req <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk_bit(ch1_selftest & ch2_selftest, 1'b0);
        pin1_req <= 1'b0;
        pin2_req <= 1'b0;
        $display("Test self-test pins done");
        cal_parity <= 1'b0;
        wait_sel(2, 1'b1);
        repeat (50) @(posedge core_clk);
        chk_bit(fail_forced, 1'b0);
        cal_parity <= 1'b1;
        srst       <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        cal_parity <= 1'b0;
        nvm_parity <= 1'b0;
        wait_sel(3, 1'b1);
        send(READ_CH1_CMD, 5'd11);
        chk_bit(got < ACC_MIN_NORMAL, 1'b1);
        send(READ_CH2_CMD, 5'd11);
        chk_bit(got < ACC_MIN_NORMAL, 1'b1);
        $display("Test parity failure done");
        finish_test();
    end
endmodule
